//--- verilog/tsra_params.svh
// Command codes, reset values, bit positions and timing of the sensor register block
`ifndef TSRA_PARAMS_SVH
`define TSRA_PARAMS_SVH
`define TSRA_CMD_LOC_TEMP  8'h00
`define TSRA_CMD_REM_TEMP  8'h01
`define TSRA_CMD_STATUS    8'h02
`define TSRA_CMD_CFG_RD    8'h03
`define TSRA_CMD_RATE_RD   8'h04
`define TSRA_CMD_LHI_RD    8'h05
`define TSRA_CMD_LLO_RD    8'h06
`define TSRA_CMD_RHI_RD    8'h07
`define TSRA_CMD_RLO_RD    8'h08
`define TSRA_CMD_CFG_WR    8'h09
`define TSRA_CMD_RATE_WR   8'h0A
`define TSRA_CMD_LHI_WR    8'h0B
`define TSRA_CMD_LLO_WR    8'h0C
`define TSRA_CMD_RHI_WR    8'h0D
`define TSRA_CMD_RLO_WR    8'h0E
`define TSRA_CMD_ONESHOT   8'h0F
`define TSRA_CMD_REM_FRAC  8'h10
`define TSRA_CMD_LOC_FRAC  8'h11
`define TSRA_CMD_ROT2      8'h16
`define TSRA_CMD_LOT2      8'h17
`define TSRA_CMD_ROT1      8'h19
`define TSRA_CMD_LOT1      8'h20
`define TSRA_CMD_OVERTEMP_RELEASE_MARGIN      8'h21
`define TSRA_CMD_MAKER     8'hFE
`define TSRA_CMD_RST       8'h00
`define TSRA_CFG_RST       8'h20
`define TSRA_RATE_RST      8'h08
`define TSRA_HI_RST        8'h46
`define TSRA_LO_RST        8'hC9
`define TSRA_OT_RST        8'h55
`define TSRA_OVERTEMP_RELEASE_MARGIN_RST      8'h0A
`define TSRA_CFG_MASK_BIT  7
`define TSRA_CFG_STBY_BIT  6
`define TSRA_CFG_JUNC_BIT  5
`define TSRA_RATE_TOP      4'h8
`define TSRA_CLK_MHZ       10
`define TSRA_BASE_INTV_US  62500
`endif

//--- verilog/tsra_pkg.sv
// Types shared by the sensor register block and its link side
package tsra_pkg;
   typedef enum logic [1:0] {
      TSRA_OP_CMD,
      TSRA_OP_WRITE,
      TSRA_OP_READ
   } tsra_op_type;

   typedef struct packed {
      tsra_op_type op;
      logic [7:0]  data;
   } tsra_req_type;

   typedef struct packed {
      logic [7:0] loc_temp;
      logic [7:0] rem_temp;
      logic [7:0] loc_frac;
      logic [7:0] rem_frac;
      logic       rem_open;
   } tsra_conv_type;
endpackage

//--- verilog/tsra_core.sv
// Command-indexed registers, conversion control and alarm logic of the sensor
`timescale 1ns/100ps
`default_nettype none
`include "tsra_params.svh"

// Functional notes
// RULE1 - Overtemp output asserts when channel temperature reaches or passes its threshold.
// RULE2 - Active overtemp output releases only below threshold minus hysteresis.
// RULE3 - One hysteresis byte at 21h serves both outputs, resets to 0Ah.
// RULE4 - Command pointer resets to zero, so plain reads return local temperature.
// RULE5 - Rate byte read at 04h, written at 0Ah, resets to 08h.
// RULE6 - Local high limit 05h/0Bh reset 46h; low limit 06h/0Ch reset C9h.
// RULE7 - Remote high limit 07h/0Dh, low 08h/0Eh, same reset values.
// RULE8 - Fraction bytes read at 10h remote and 11h local, reset zero.
// RULE9 - Primary thresholds at 19h remote and 20h local, reset 55h.
// RULE10 - Secondary thresholds at 16h remote and 17h local when built.
// RULE11 - One-shot 0Fh in standby runs one conversion then stays standby.
// RULE12 - One-shot during a conversion is ignored.
// RULE13 - One-shot between auto conversions starts at once and restarts timer.
// RULE14 - Config bit 7 masks the interrupt output, resets zero.
// RULE15 - Config bit 6 selects standby when one, autoconvert when zero.
// RULE16 - Config bit 5 selects substrate junction when one, resets one.
// RULE17 - Config bits 4 to 0 always read zero.
// RULE18 - Status resets with busy set and all other flags clear.
// RULE19 - Status read clears bits 6 to 2 and interrupt latch.
// RULE20 - Status bits 1 and 0 follow their condition, never cleared by reads.
// RULE21 - Secondary overtemp has no status flag, only its pin.
// RULE22 - Bus accesses never corrupt, nor get corrupted by, conversion updates.
// RULE23 - Status bit 7 busy, 6/5 local, 4/3 remote alarms, 2 open.
// RULE24 - Only four low rate bits count, codes 0 to 8, reset 08h.
// RULE25 - Alarm flags raise at or beyond high limit, at or below low.
// RULE26 - Writes to read-only codes leave all registers unchanged.
module tsra_core
   import tsra_pkg::*;
#(
   parameter int unsigned BASE_INTV_CYC = `TSRA_BASE_INTV_US * `TSRA_CLK_MHZ,
   parameter bit          HAS_OT2       = 1'b1,
   parameter logic [7:0]  MAKER_ID      = 8'h5A  // Arbitrary identity value
) (
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          link_clk,
   input  wire logic          lk_req_valid,
   input  wire tsra_req_type  lk_req,
   output logic               lk_ready,
   output logic               lk_rsp_valid,
   output logic [7:0]         lk_rsp_data,
   output logic               conv_start,
   input  wire logic          conv_done,
   input  wire tsra_conv_type conv_res,
   output logic               junction_type_select,
   output logic               overtemp_out_primary,
   output logic               overtemp_out_secondary,
   output logic               alert_o,
   output logic               alert_oe
);
   typedef enum logic {TSRA_IDLE, TSRA_CONV} tsra_state_type;

   // Link domain
   tsra_req_type   req_q;
   logic           req_tgl_q;
   logic           pend_q;
   logic           ack_s1_q, ack_s2_q, ack_seen_q;
   logic           rsp_valid_q;
   logic [7:0]     rsp_data_q;
   // Reference domain
   logic           req_s1_q, req_s2_q, req_s3_q;
   logic           ack_tgl_q;
   logic [7:0]     ans_q;
   logic [7:0]     cmd_q, cfg_q, rate_q, overtemp_release_margin_q;
   logic [7:0]     hi_q [2];
   logic [7:0]     lo_q [2];
   logic [7:0]     ot1_thr_q [2];
   logic [7:0]     ot2_thr_q [2];
   logic [7:0]     temp_q [2];
   logic [7:0]     frac_q [2];
   logic [4:0]     alarm_q;
   logic           alert_q;
   logic [1:0]     ot1_q, ot2_q, ot1_d, ot2_d;
   logic           pri_q, sec_q;
   tsra_state_type state_q;
   logic           start_q;
   logic [31:0]    timer_q;
   logic           evt, is_cmd, is_wr, is_rd, oneshot, stat_rd;
   logic [7:0]     rd_val, status;
   logic [4:0]     alarm_set;
   logic [7:0]     conv_t [2];

   function automatic logic ge_s(input logic [7:0] a, input logic [7:0] b);
      ge_s = $signed(a) >= $signed(b);
   endfunction

   function automatic logic ot_next(input logic p, input logic [7:0] t,
                                    input logic [7:0] thr, input logic [7:0] hy);
      logic signed [9:0] rel;
      rel = 10'($signed(thr)) - 10'($signed(hy));
      if (ge_s(t, thr))
         ot_next = 1'b1;
      else if (10'($signed(t)) < rel)
         ot_next = 1'b0;
      else
         ot_next = p;
   endfunction

   // Link side: one request in flight, answered by toggle handshake
   assign lk_ready     = !pend_q;
   assign lk_rsp_valid = rsp_valid_q;
   assign lk_rsp_data  = rsp_data_q;

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_q     <= '{op: TSRA_OP_CMD, data: 8'h00};
         req_tgl_q <= 1'b0;
      end else if (lk_req_valid && !pend_q) begin
         req_q     <= lk_req;
         req_tgl_q <= !req_tgl_q;
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_s1_q   <= 1'b0;
         ack_s2_q   <= 1'b0;
         ack_seen_q <= 1'b0;
      end else begin
         ack_s1_q   <= ack_tgl_q;
         ack_s2_q   <= ack_s1_q;
         ack_seen_q <= ack_s2_q;
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q      <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_data_q  <= 8'h00;
      end else begin
         rsp_valid_q <= 1'b0;
         if (lk_req_valid && !pend_q) begin
            pend_q <= 1'b1;
         end else if (ack_s2_q != ack_seen_q) begin
            pend_q      <= 1'b0;
            rsp_valid_q <= 1'b1;
            rsp_data_q  <= ans_q;
         end
      end
   end

   // Reference side request detect
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
      end else begin
         req_s1_q <= req_tgl_q;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
      end
   end

   assign evt     = req_s2_q ^ req_s3_q;
   assign is_cmd  = evt && (req_q.op == TSRA_OP_CMD);
   assign is_wr   = evt && (req_q.op == TSRA_OP_WRITE);
   assign is_rd   = evt && (req_q.op == TSRA_OP_READ);
   assign stat_rd = is_rd && (cmd_q == `TSRA_CMD_STATUS);
   assign oneshot = (is_cmd && req_q.data == `TSRA_CMD_ONESHOT)
                    || (is_wr && cmd_q == `TSRA_CMD_ONESHOT);

   // RULE23 status layout
   // RULE21 no secondary flag
   assign status = {state_q == TSRA_CONV, alarm_q, ot1_q[1], ot1_q[0]};

   always_comb begin
      rd_val = 8'h00;
      case (cmd_q)
         `TSRA_CMD_LOC_TEMP: rd_val = temp_q[0];
         `TSRA_CMD_REM_TEMP: rd_val = temp_q[1];
         `TSRA_CMD_STATUS:   rd_val = status;
         // RULE17 reserved bits zero
         `TSRA_CMD_CFG_RD:   rd_val = {cfg_q[7:5], 5'h00};
         `TSRA_CMD_RATE_RD:  rd_val = rate_q;
         `TSRA_CMD_LHI_RD:   rd_val = hi_q[0];
         `TSRA_CMD_LLO_RD:   rd_val = lo_q[0];
         `TSRA_CMD_RHI_RD:   rd_val = hi_q[1];
         `TSRA_CMD_RLO_RD:   rd_val = lo_q[1];
         `TSRA_CMD_REM_FRAC: rd_val = frac_q[1];
         `TSRA_CMD_LOC_FRAC: rd_val = frac_q[0];
         `TSRA_CMD_ROT2:     rd_val = HAS_OT2 ? ot2_thr_q[1] : 8'h00;
         `TSRA_CMD_LOT2:     rd_val = HAS_OT2 ? ot2_thr_q[0] : 8'h00;
         `TSRA_CMD_ROT1:     rd_val = ot1_thr_q[1];
         `TSRA_CMD_LOT1:     rd_val = ot1_thr_q[0];
         `TSRA_CMD_OVERTEMP_RELEASE_MARGIN:     rd_val = overtemp_release_margin_q;
         `TSRA_CMD_MAKER:    rd_val = MAKER_ID;
         default:            rd_val = 8'h00;
      endcase
   end

   // Answer word held until the next request, so the link reads it stable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ans_q     <= 8'h00;
         ack_tgl_q <= 1'b0;
      end else if (evt) begin
         ans_q     <= is_rd ? rd_val : 8'h00;
         ack_tgl_q <= !ack_tgl_q;
      end
   end

   // RULE4 pointer from command byte
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         cmd_q <= `TSRA_CMD_RST;
      else if (is_cmd)
         cmd_q <= req_q.data;
   end

   // RULE26 only writable codes decode; RULE22 single writer per register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q        <= `TSRA_CFG_RST;
         rate_q       <= `TSRA_RATE_RST;
         hi_q         <= '{`TSRA_HI_RST, `TSRA_HI_RST};
         lo_q         <= '{`TSRA_LO_RST, `TSRA_LO_RST};
         ot1_thr_q    <= '{`TSRA_OT_RST, `TSRA_OT_RST};
         ot2_thr_q    <= '{`TSRA_OT_RST, `TSRA_OT_RST};
         overtemp_release_margin_q       <= `TSRA_OVERTEMP_RELEASE_MARGIN_RST;
      end else if (is_wr) begin
         case (cmd_q)
            `TSRA_CMD_CFG_WR:  cfg_q        <= req_q.data;
            // RULE5 rate write
            `TSRA_CMD_RATE_WR: rate_q       <= req_q.data;
            // RULE6 local limits
            `TSRA_CMD_LHI_WR:  hi_q[0]      <= req_q.data;
            `TSRA_CMD_LLO_WR:  lo_q[0]      <= req_q.data;
            // RULE7 remote limits
            `TSRA_CMD_RHI_WR:  hi_q[1]      <= req_q.data;
            `TSRA_CMD_RLO_WR:  lo_q[1]      <= req_q.data;
            // RULE10 secondary thresholds
            `TSRA_CMD_ROT2:    ot2_thr_q[1] <= req_q.data;
            `TSRA_CMD_LOT2:    ot2_thr_q[0] <= req_q.data;
            // RULE9 primary thresholds
            `TSRA_CMD_ROT1:    ot1_thr_q[1] <= req_q.data;
            `TSRA_CMD_LOT1:    ot1_thr_q[0] <= req_q.data;
            // RULE3 shared hysteresis
            `TSRA_CMD_OVERTEMP_RELEASE_MARGIN:    overtemp_release_margin_q       <= req_q.data;
            default:           cfg_q        <= cfg_q;
         endcase
      end
   end

   // RULE16 junction select
   assign junction_type_select = cfg_q[`TSRA_CFG_JUNC_BIT];

   // RULE8 results captured only on completion
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         temp_q <= '{8'h00, 8'h00};
         frac_q <= '{8'h00, 8'h00};
      end else if (conv_done && state_q == TSRA_CONV) begin
         temp_q <= '{conv_res.loc_temp, conv_res.rem_temp};
         frac_q <= '{conv_res.loc_frac, conv_res.rem_frac};
      end
   end

   // RULE24 codes above top run at top rate
   function automatic logic [31:0] interval(input logic [7:0] rate);
      logic [3:0] code;
      code = (rate[3:0] > `TSRA_RATE_TOP) ? `TSRA_RATE_TOP : rate[3:0];
      interval = BASE_INTV_CYC << (`TSRA_RATE_TOP - code);
   endfunction

   // Conversion sequencer; starts at once after reset, so busy shows set
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= TSRA_CONV;
         start_q <= 1'b1;
         timer_q <= 32'h0000_0000;
      end else begin
         start_q <= 1'b0;
         if (timer_q != 32'hFFFF_FFFF)
            timer_q <= timer_q + 32'h0000_0001;
         case (state_q)
            TSRA_IDLE: begin
               // RULE11 RULE13 RULE15 start and timer restart
               if (oneshot || (!cfg_q[`TSRA_CFG_STBY_BIT]
                               && timer_q + 32'h0000_0001 >= interval(rate_q))) begin
                  start_q <= 1'b1;
                  state_q <= TSRA_CONV;
                  timer_q <= 32'h0000_0000;
               end
            end
            // RULE12 one-shot ignored while converting
            TSRA_CONV: if (conv_done) state_q <= TSRA_IDLE;
            default:   state_q <= TSRA_IDLE;
         endcase
      end
   end
   assign conv_start = start_q;

   assign conv_t = '{conv_res.loc_temp, conv_res.rem_temp};
   // RULE25 limit compares on fresh results
   assign alarm_set = {ge_s(conv_t[0], hi_q[0]), ge_s(lo_q[0], conv_t[0]),
                       ge_s(conv_t[1], hi_q[1]), ge_s(lo_q[1], conv_t[1]),
                       conv_res.rem_open} & {5{conv_done && state_q == TSRA_CONV}};

   // RULE18 RULE19 sticky flags; a new set wins over the read clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         alarm_q <= 5'h00;
         alert_q <= 1'b0;
      end else begin
         alarm_q <= (stat_rd ? 5'h00 : alarm_q) | alarm_set;
         alert_q <= (stat_rd ? 1'b0 : alert_q) | (|alarm_set);
      end
   end

   // RULE14 mask gates the open-drain interrupt
   assign alert_o  = 1'b0;
   assign alert_oe = alert_q && !cfg_q[`TSRA_CFG_MASK_BIT];

   // RULE1 RULE2 RULE20 continuous compare with hysteresis
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         ot1_d[c] = ot_next(ot1_q[c], temp_q[c], ot1_thr_q[c], overtemp_release_margin_q);
         ot2_d[c] = HAS_OT2 && ot_next(ot2_q[c], temp_q[c], ot2_thr_q[c], overtemp_release_margin_q);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ot1_q <= 2'h0;
         ot2_q <= 2'h0;
         pri_q <= 1'b0;
         sec_q <= 1'b0;
      end else begin
         ot1_q <= ot1_d;
         ot2_q <= ot2_d;
         pri_q <= |ot1_d;
         sec_q <= |ot2_d;
      end
   end
   assign overtemp_out_primary   = pri_q;
   assign overtemp_out_secondary = sec_q;

   chk_ot_assert: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
      ge_s(temp_q[0], ot1_thr_q[0]) |=> overtemp_out_primary)
      else $error("primary output not set at threshold");

   chk_ot_release: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
      $fell(ot1_q[0]) |-> 10'($signed($past(temp_q[0])))
         < 10'($signed($past(ot1_thr_q[0]))) - 10'($signed($past(overtemp_release_margin_q))))
      else $error("primary released above hysteresis band");

   chk_oneshot_busy: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
      (oneshot && state_q == TSRA_CONV && !conv_done) |=> !conv_start)
      else $error("one-shot during conversion started another");

   chk_oneshot_run: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE11
      (oneshot && state_q == TSRA_IDLE) |=> conv_start && timer_q == 32'h0000_0000
         ##1 status[7])
      else $error("one-shot did not start a conversion");

   chk_standby_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE15
      (state_q == TSRA_IDLE && cfg_q[`TSRA_CFG_STBY_BIT] && !oneshot) |=> !conv_start)
      else $error("conversion started in standby");

   chk_status_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE19
      (stat_rd && !conv_done) |=> alarm_q == 5'h00 && !alert_oe)
      else $error("status read left flags set");

   chk_status_keep: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE20
      (stat_rd && ot1_q[0] && ge_s(temp_q[0], ot1_thr_q[0])) |=> status[0])
      else $error("status read cleared overtemp flags");

   chk_cfg_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE17
      (is_rd && cmd_q == `TSRA_CMD_CFG_RD) |=> ans_q[4:0] == 5'h00)
      else $error("reserved config bits read nonzero");

   chk_ro_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE26
      (is_wr && cmd_q <= `TSRA_CMD_RLO_RD)
         |=> $stable(cfg_q) && $stable(overtemp_release_margin_q) && $stable(hi_q[0]) && $stable(lo_q[0]))
      else $error("write to read-only code changed a register");

   chk_link_answer: assert property (@(posedge link_clk) disable iff (!rst_n) // answer pulse lasts one link cycle
      lk_rsp_valid |-> !pend_q ##1 !lk_rsp_valid)
      else $error("answer pulse longer than one cycle");
endmodule
`default_nettype wire

//--- sim/tsra_host_model.sv
// Host-side link master model with a clock that runs from time zero until the first transfer ends, then only during transfers
`timescale 1ns/100ps
`default_nettype none
module tsra_host_model
   import tsra_pkg::*;
(
   output logic            link_clk,
   output logic            lk_req_valid,
   output var tsra_req_type lk_req,
   input  wire logic       lk_ready,
   input  wire logic       lk_rsp_valid,
   input  wire logic [7:0] lk_rsp_data
);
   logic clk_run;

   initial begin
      link_clk = 1'b0;
      clk_run = 1'b1;
      lk_req_valid = 1'b0;
      lk_req = '{op: TSRA_OP_READ, data: 8'h00};
   end

   // Parked low between frames; the 48 ns grid never meets a ref rising edge
   always #24 link_clk = clk_run ? ~link_clk : 1'b0;

   task automatic xfer(input tsra_op_type op, input logic [7:0] wdata,
                       output logic [7:0] rdata, output logic ok);
      int n;
      ok = 1'b0;
      rdata = 8'h00;
      clk_run = 1'b1;
      @(posedge link_clk);
      lk_req_valid <= 1'b1;
      lk_req <= '{op: op, data: wdata};
      // Request held until an edge sees ready high
      for (n = 0; n < 64; n++) begin
         @(posedge link_clk);
         if (lk_ready === 1'b1)
            break;
      end
      lk_req_valid <= 1'b0;
      // Released data lines must not keep the old value
      lk_req.data <= ~wdata;
      for (n = 0; n < 64 && !ok; n++) begin
         @(posedge link_clk);
         #1;
         if (lk_rsp_valid === 1'b1) begin
            ok = 1'b1;
            rdata = lk_rsp_data;
         end
      end
      repeat (3) @(posedge link_clk);
      clk_run = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- sim/temp_sensor_regs_alarms_tb.sv
// Self-checking bench for the sensor register and alarm block
`timescale 1ns/100ps
`default_nettype none
`include "tsra_params.svh"
module temp_sensor_regs_alarms_tb
   import tsra_pkg::*;
   ;
   localparam logic [7:0] ID_VAL = 8'h3C;  // Arbitrary identity value
   logic          ref_clk, rst_n, link_clk, lk_req_valid, lk_ready, lk_rsp_valid;
   logic          conv_start, jsel, ot1, ot2, alert_o, alert_oe;
   logic          conv_done = 1'b0;
   logic [7:0]    lk_rsp_data, rdata;
   tsra_req_type  lk_req;
   tsra_conv_type conv_res;
   int            n_mismatch, samples_checked, adc_cyc, s0;
   // Owned by the converter stand-in only
   int            adc_cnt = 0, n_starts = 0;
   // Command code above, reset value below
   logic [15:0]   rst_tab [13] = '{16'h0320, 16'h0408, 16'h0546, 16'h06C9, 16'h0746,
      16'h08C9, 16'h1000, 16'h1100, 16'h1655, 16'h1755, 16'h1955, 16'h2055, 16'h210A};
   // Write code, read code, data
   logic [23:0]   wr_tab [10] = '{24'h0A0407, 24'h0B053C, 24'h0C06C0, 24'h0D073C,
      24'h0E08C0, 24'h161670, 24'h171770, 24'h19193C, 24'h202032, 24'h212105};

   tsra_core #(.BASE_INTV_CYC(200), .HAS_OT2(1'b1), .MAKER_ID(ID_VAL)) dut_u (
      .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
      .lk_req_valid(lk_req_valid), .lk_req(lk_req), .lk_ready(lk_ready),
      .lk_rsp_valid(lk_rsp_valid), .lk_rsp_data(lk_rsp_data),
      .conv_start(conv_start), .conv_done(conv_done), .conv_res(conv_res),
      .junction_type_select(jsel), .overtemp_out_primary(ot1),
      .overtemp_out_secondary(ot2), .alert_o(alert_o), .alert_oe(alert_oe));

   tsra_host_model host_u (
      .link_clk(link_clk), .lk_req_valid(lk_req_valid), .lk_req(lk_req),
      .lk_ready(lk_ready), .lk_rsp_valid(lk_rsp_valid), .lk_rsp_data(lk_rsp_data));

   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;

   // Converter stand-in: done pulse a set time after each start
   always @(posedge ref_clk) begin
      conv_done <= (adc_cnt == 1);
      if (conv_start === 1'b1) begin
         adc_cnt <= adc_cyc;
         n_starts <= n_starts + 1;
      end else if (adc_cnt != 0) begin
         adc_cnt <= adc_cnt - 1;
      end
   end

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_pin(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic link(input tsra_op_type op, input logic [7:0] d);
      logic ok;
      host_u.xfer(op, d, rdata, ok);
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("unexpected link answer: expected response seen none");
         end_sim();
      end
   endtask

   task automatic wr(input logic [7:0] code, input logic [7:0] d);
      link(TSRA_OP_CMD, code);
      link(TSRA_OP_WRITE, d);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] code, input logic [7:0] exp);
      link(TSRA_OP_CMD, code);
      link(TSRA_OP_READ, 8'h00);
      check_byte(what, exp, rdata);
   endtask

   // Second one-shot lands while the first conversion is still busy
   task automatic convert(input logic [7:0] lt, input logic [7:0] rt, input logic op);
      int n;
      @(posedge ref_clk);
      conv_res <= '{loc_temp: lt, rem_temp: rt, loc_frac: 8'hA0, rem_frac: 8'h60, rem_open: op};
      s0 = n_starts;
      link(TSRA_OP_CMD, `TSRA_CMD_ONESHOT);
      link(TSRA_OP_CMD, `TSRA_CMD_ONESHOT);
      for (n = 0; n < 500 && (n_starts == s0 || adc_cnt != 0); n++)
         @(posedge ref_clk);
      if (n == 500) begin
         n_mismatch++;
         $display("unexpected conversion: expected done seen none");
         end_sim();
      end
      repeat (3) @(posedge ref_clk);
   endtask

   initial begin
      rst_n = 1'b0;
      conv_res = '0;
      adc_cyc = 100;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      link(TSRA_OP_READ, 8'h00);
      check_byte("plain read", 8'h00, rdata);
      rd_chk("status", `TSRA_CMD_STATUS, 8'h80);
      check_pin("junction", 1'b1, jsel);
      check_pin("alert data", 1'b0, alert_o);
      adc_cyc = 30;
      foreach (rst_tab[i])
         rd_chk("reset value", rst_tab[i][15:8], rst_tab[i][7:0]);
      rd_chk("identity", `TSRA_CMD_MAKER, ID_VAL);
      foreach (wr_tab[i]) begin
         wr(wr_tab[i][23:16], wr_tab[i][7:0]);
         rd_chk("write back", wr_tab[i][15:8], wr_tab[i][7:0]);
      end
      wr(`TSRA_CMD_LHI_RD, 8'h00);
      rd_chk("read-only code", `TSRA_CMD_LHI_RD, 8'h3C);
      wr(`TSRA_CMD_CFG_WR, 8'hFF);
      rd_chk("config", `TSRA_CMD_CFG_RD, 8'hE0);
      wr(`TSRA_CMD_CFG_WR, 8'h40);
      rd_chk("config", `TSRA_CMD_CFG_RD, 8'h40);
      check_pin("junction", 1'b0, jsel);
      // Let an automatic conversion in flight finish
      repeat (50) @(posedge ref_clk);
      convert(8'h32, 8'h00, 1'b0);
      repeat (500) @(posedge ref_clk);
      check_byte("starts", 8'h01, 8'(n_starts - s0));
      check_pin("ot primary", 1'b1, ot1);
      check_pin("ot secondary", 1'b0, ot2);
      rd_chk("status", `TSRA_CMD_STATUS, 8'h01);
      rd_chk("local temp", `TSRA_CMD_LOC_TEMP, 8'h32);
      rd_chk("local frac", `TSRA_CMD_LOC_FRAC, 8'hA0);
      rd_chk("remote frac", `TSRA_CMD_REM_FRAC, 8'h60);
      convert(8'h3C, 8'h00, 1'b0);
      check_pin("alert", 1'b1, alert_oe);
      rd_chk("status", `TSRA_CMD_STATUS, 8'h41);
      check_pin("alert", 1'b0, alert_oe);
      rd_chk("status", `TSRA_CMD_STATUS, 8'h01);
      check_pin("ot primary", 1'b1, ot1);
      convert(8'h2D, 8'h00, 1'b0);
      check_pin("ot primary", 1'b1, ot1);
      wr(`TSRA_CMD_OVERTEMP_RELEASE_MARGIN, 8'h04);
      repeat (2) @(posedge ref_clk);
      check_pin("ot primary", 1'b0, ot1);
      rd_chk("status", `TSRA_CMD_STATUS, 8'h00);
      wr(`TSRA_CMD_CFG_WR, 8'hC0);
      convert(8'h70, 8'hC0, 1'b1);
      check_pin("masked alert", 1'b0, alert_oe);
      check_pin("ot secondary", 1'b1, ot2);
      wr(`TSRA_CMD_CFG_WR, 8'h40);
      check_pin("alert", 1'b1, alert_oe);
      rd_chk("status", `TSRA_CMD_STATUS, 8'h4D);
      // Autoconvert at rate code 07h: 400-cycle interval; one-shot must restart it
      wr(`TSRA_CMD_CFG_WR, 8'h00);
      repeat (100) @(posedge ref_clk);
      s0 = n_starts;
      link(TSRA_OP_CMD, `TSRA_CMD_ONESHOT);
      repeat (330) @(posedge ref_clk);
      check_byte("restarted timer", 8'h01, 8'(n_starts - s0));
      repeat (100) @(posedge ref_clk);
      check_byte("next auto start", 8'h02, 8'(n_starts - s0));
      end_sim();
   end
endmodule
`default_nettype wire
